// ---- core/dsl_pkg.sv ----
// constants and types shared by the serial converter load device and host
// How it works
// - device has 24-bit shift register, frame-select starts
// - data sampled on falling clock while selected
// - first two frame bits pick power mode
// - last six frame bits are ignored
// - eighteenth falling edge executes the update
// - host may release select after eighteenth bit
// - select high at least 20 ns between frames
// - normal write keeps select low 24 edges
// - early select rise aborts and clears shifter
// - aborted write keeps code and mode
// - reset loads zero code until valid write
// - mode 00 normal, 01 1k, 10 100k, 11 open
// - power-down shuts amplifier, selects termination
// - power-down never alters stored code
// - leaving power-down needs 50 us recovery
// - data sent most significant bit first
// - byte hosts keep select low between bytes
// - code is straight unsigned binary
package dsl_pkg;
  localparam int FRAME_BITS   = 24;
  localparam int MODE_BITS    = 2;
  localparam int CODE_BITS    = 16;
  localparam int EXEC_EDGE    = MODE_BITS + CODE_BITS;
  localparam int CNT_W        = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
  localparam logic [CNT_W-1:0] CNT_EXEC = 5'h12;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;
  localparam int CLK_NS       = 40;
  localparam int SEL_HIGH_NS  = 20;
  localparam int SEL_HIGH_CYC = (SEL_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_US   = 50;
  localparam int RECOVER_CYC  = (RECOVER_US * 1000) / CLK_NS;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 16'h0000;

  typedef enum logic [1:0] {
    DSL_MODE_NORMAL = 2'b00,
    DSL_MODE_1K     = 2'b01,
    DSL_MODE_100K   = 2'b10,
    DSL_MODE_OPEN   = 2'b11
  } dsl_mode_t;

  localparam dsl_mode_t MODE_RESET = DSL_MODE_NORMAL;
endpackage

// ---- core/dsl_link_if.sv ----
// three-wire serial link between host and converter
interface dsl_link_if;
  logic sync_n;
  logic sclk;
  logic din;
  modport device (input sync_n, input sclk, input din);
  modport host   (output sync_n, output sclk, output din);
endinterface

// ---- core/dsl_device.sv ----
// converter serial front end: shift register, frame control, mode and code registers
module dsl_device
  import dsl_pkg::*;
#(
  parameter int RECOVER_CYCLES = RECOVER_CYC
) (
  // clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_arst_n,
  // serial link
  dsl_link_if.device                link,
  // converter side
  output logic [CODE_BITS-1:0]      o_code,
  output dsl_mode_t                 o_mode,
  output logic                      o_amp_on,
  output logic                      o_term_1k,
  output logic                      o_term_100k,
  output logic                      o_settled,
  output logic                      o_update,
  output logic                      o_abort
);
  // synchronisers
  logic [1:0] sync_s_reg;
  logic [1:0] sclk_s_reg;
  logic [1:0] din_s_reg;
  logic       sync_d_reg;
  logic       sclk_d_reg;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_s_reg <= 2'h3;
      sclk_s_reg <= 2'h0;
      din_s_reg  <= 2'h0;
      sync_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
    end else begin
      sync_s_reg <= {sync_s_reg[0], link.sync_n};
      sclk_s_reg <= {sclk_s_reg[0], link.sclk};
      din_s_reg  <= {din_s_reg[0], link.din};
      sync_d_reg <= sync_s_reg[1];
      sclk_d_reg <= sclk_s_reg[1];
    end
  end

  logic sync_n;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  assign sync_n    = sync_s_reg[1];
  assign sclk_fall = sclk_d_reg && !sclk_s_reg[1];
  assign sync_fall = sync_d_reg && !sync_n;
  assign sync_rise = !sync_d_reg && sync_n;

  // field decode of the eighteen meaningful frame bits
  function automatic dsl_mode_t head_mode(input logic [EXEC_EDGE-1:0] head);
    return dsl_mode_t'(head[EXEC_EDGE-1 -: MODE_BITS]);
  endfunction

  function automatic logic [CODE_BITS-1:0] head_code(input logic [EXEC_EDGE-1:0] head);
    return head[CODE_BITS-1:0];
  endfunction

  // a frame closed before this many falls is an abort
  function automatic logic short_frame(input logic [CNT_W-1:0] cnt);
    return cnt < CNT_EXEC;
  endfunction

  // frame shifting and edge counting
  logic [FRAME_BITS-1:0] shift_reg;
  logic [CNT_W-1:0]      count_reg;
  logic                  active_reg;
  logic                  exec;
  logic                  abort_now;
  assign exec      = active_reg && !sync_n && sclk_fall
                     && (count_reg == CNT_EXEC - CNT_ONE);
  assign abort_now = sync_rise && active_reg && short_frame(count_reg);

  // shift register, cleared at frame start and by an aborted frame
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_reg <= '0;
    end else if (sync_fall) begin
      shift_reg <= '0;
    end else if (sync_n) begin
      if (active_reg && short_frame(count_reg)) begin
        shift_reg <= '0;
      end
    end else if (active_reg && sclk_fall) begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], din_s_reg[1]};
    end
  end

  // falling serial clock edges of the open frame, saturating at a full frame
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_reg <= CNT_ZERO;
    end else if (sync_fall || sync_n) begin
      count_reg <= CNT_ZERO;
    end else if (active_reg && sclk_fall && count_reg != CNT_FULL) begin
      count_reg <= count_reg + CNT_ONE;
    end
  end

  // frame open from select falling until select rises or the last bit
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      active_reg <= 1'b0;
    end else if (sync_fall) begin
      active_reg <= 1'b1;
    end else if (sync_n) begin
      active_reg <= 1'b0;
    end else if (sclk_fall && count_reg == CNT_FULL - CNT_ONE) begin
      active_reg <= 1'b0;
    end
  end

  // bit just shifted is the last code bit; later six bits never reach registers
  logic [EXEC_EDGE-1:0] frame_head;
  dsl_mode_t            new_mode;
  assign frame_head = {shift_reg[EXEC_EDGE-2:0], din_s_reg[1]};
  assign new_mode   = head_mode(frame_head);

  // code register: a power-down frame keeps the stored code
  logic [CODE_BITS-1:0] code_reg;
  dsl_mode_t            mode_reg;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      code_reg <= CODE_RESET;
    end else if (exec && new_mode == DSL_MODE_NORMAL) begin
      code_reg <= head_code(frame_head);
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_reg <= MODE_RESET;
    end else if (exec) begin
      mode_reg <= new_mode;
    end
  end

  // output stage control, one cycle behind the mode
  logic amp_reg;
  logic t1k_reg;
  logic t100k_reg;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      amp_reg <= 1'b1;
    end else begin
      amp_reg <= (mode_reg == DSL_MODE_NORMAL);
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      t1k_reg <= 1'b0;
    end else begin
      t1k_reg <= (mode_reg == DSL_MODE_1K);
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      t100k_reg <= 1'b0;
    end else begin
      t100k_reg <= (mode_reg == DSL_MODE_100K);
    end
  end

  // recovery timer after leaving power-down
  localparam int REC_W = $clog2(RECOVER_CYCLES + 1);
  logic [REC_W-1:0] rec_reg;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rec_reg <= '0;
    end else if (exec && mode_reg != DSL_MODE_NORMAL && new_mode == DSL_MODE_NORMAL) begin
      rec_reg <= REC_W'(RECOVER_CYCLES);
    end else if (rec_reg != '0) begin
      rec_reg <= rec_reg - REC_W'(1);
    end
  end

  // settled rises together with the amplifier unless recovery is still running
  logic settled_reg;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      settled_reg <= 1'b1;
    end else begin
      settled_reg <= (mode_reg == DSL_MODE_NORMAL) && (rec_reg == '0);
    end
  end

  // event pulses
  logic upd_reg;
  logic abt_reg;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      upd_reg <= 1'b0;
    end else begin
      upd_reg <= exec;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      abt_reg <= 1'b0;
    end else begin
      abt_reg <= abort_now;
    end
  end

  assign o_code      = code_reg;
  assign o_mode      = mode_reg;
  assign o_amp_on    = amp_reg;
  assign o_term_1k   = t1k_reg;
  assign o_term_100k = t100k_reg;
  assign o_settled   = settled_reg;
  assign o_update    = upd_reg;
  assign o_abort     = abt_reg;
endmodule

// ---- core/dsl_host.sv ----
// host end: sends one 24-bit frame per request, divides its clock for the link
module dsl_host
  import dsl_pkg::*;
#(
  parameter int HALF_DIV = 4
) (
  // clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_arst_n,
  // serial link
  dsl_link_if.host                  link,
  // request
  input  wire logic                 i_valid,
  input  wire dsl_mode_t            i_mode,
  input  wire logic [CODE_BITS-1:0] i_code,
  input  wire logic                 i_abort,
  output logic                      o_ready,
  output logic                      o_done
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SEND = 2'b01,
    H_GAP  = 2'b10
  } dsl_hstate_t;

  dsl_hstate_t           state_reg;
  logic [FRAME_BITS-1:0] data_reg;
  logic [CNT_W-1:0]      bits_reg;
  logic [7:0]            div_reg;
  logic                  sclk_reg;
  logic                  sync_reg;
  logic                  done_reg;
  logic                  tick;
  assign tick = (div_reg == 8'(HALF_DIV - 1));

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_reg <= 8'h00;
    end else if (state_reg != H_SEND || tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= H_IDLE;
      data_reg  <= '0;
      bits_reg  <= CNT_ZERO;
      sclk_reg  <= 1'b0;
      sync_reg  <= 1'b1;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        H_IDLE: begin
          if (i_valid) begin
            data_reg  <= {i_mode, i_code, {(FRAME_BITS - EXEC_EDGE){1'b0}}};
            bits_reg  <= CNT_ZERO;
            sync_reg  <= 1'b0;
            sclk_reg  <= 1'b1;
            state_reg <= H_SEND;
          end
        end
        H_SEND: begin
          if (i_abort) begin
            sync_reg  <= 1'b1;
            sclk_reg  <= 1'b0;
            state_reg <= H_GAP;
          end else if (tick && sclk_reg) begin
            sclk_reg <= 1'b0;
            bits_reg <= bits_reg + CNT_ONE;
          end else if (tick && bits_reg == CNT_FULL) begin
            // select rises with the serial clock left low, so it idles low
            sync_reg  <= 1'b1;
            done_reg  <= 1'b1;
            state_reg <= H_GAP;
          end else if (tick) begin
            sclk_reg <= 1'b1;
            data_reg <= {data_reg[FRAME_BITS-2:0], 1'b0};
          end
        end
        H_GAP: begin
          state_reg <= H_IDLE;
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  assign link.sync_n = sync_reg;
  assign link.sclk   = sclk_reg;
  assign link.din    = data_reg[FRAME_BITS-1];
  assign o_ready     = (state_reg == H_IDLE);
  assign o_done      = done_reg;
endmodule

// ---- dv/dsl_asserts.sv ----
// protocol checks on the serial link between host and converter
module dsl_asserts (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // serial link
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] fall_cnt_reg;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  // falling serial clock edges seen in the current frame
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fall_cnt_reg <= 5'h00;
    end else if (sync_n) begin
      fall_cnt_reg <= 5'h00;
    end else if ($fell(sclk)) begin
      fall_cnt_reg <= fall_cnt_reg + 5'h01;
    end
  end

  sequence high_phase;
    sclk [*4] ##1 !sclk;
  endsequence

  sequence low_phase;
    !sclk [*4];
  endsequence

  AST_SCLK_IDLE: assert property (sync_n && $past(sync_n) |-> !sclk)
    else $error("serial clock active while deselected");
  AST_FRAME_START: assert property ($fell(sync_n) |-> high_phase)
    else $error("frame start phase wrong");
  AST_LOW_PHASE: assert property ($fell(sclk) && !sync_n |-> low_phase)
    else $error("serial clock low phase too short");
  AST_DIN_STABLE: assert property ($changed(din) && !sync_n && !$fell(sync_n) |-> $rose(sclk))
    else $error("data changed away from rising clock");
  AST_MAX_FALLS: assert property (fall_cnt_reg <= 5'h18)
    else $error("more than 24 clock falls in a frame");
  AST_GAP: assert property ($rose(sync_n) |=> sync_n)
    else $error("select high gap too short");
  AST_FRAME_LEN: assert property ($fell(sync_n) |-> ##[1:220] $rose(sync_n))
    else $error("frame never ended");
  AST_SCLK_SEL: assert property ($rose(sclk) |-> !sync_n)
    else $error("serial clock rose while deselected");
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench: host and converter joined over the serial link
module tb_top;
  import dsl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 i_clock, i_arst_n, valid, abort, ready, done;
  logic                 amp_on, term_1k, term_100k, settled, upd, abt;
  logic [CODE_BITS-1:0] code, dev_code, exp_code;
  dsl_mode_t            mode, dev_mode, exp_mode;
  logic [31:0]          rng;
  int                   err_total, check_count;
  localparam int        HALF    = 4;
  localparam int        REC_SIM = 10;

  dsl_link_if dsl_link_if_i ();
  dsl_host #(.HALF_DIV(HALF)) dsl_host_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .link(dsl_link_if_i), .i_valid(valid), .i_mode(mode), .i_code(code), .i_abort(abort),
    .o_ready(ready), .o_done(done));
  dsl_device #(.RECOVER_CYCLES(REC_SIM)) dsl_device_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .link(dsl_link_if_i), .o_code(dev_code), .o_mode(dev_mode), .o_amp_on(amp_on),
    .o_term_1k(term_1k), .o_term_100k(term_100k), .o_settled(settled), .o_update(upd),
    .o_abort(abt));
  dsl_asserts dsl_asserts_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .sync_n(dsl_link_if_i.sync_n), .sclk(dsl_link_if_i.sclk), .din(dsl_link_if_i.din));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [2:0] exp_out(input dsl_mode_t m);
    return {m == DSL_MODE_NORMAL, m == DSL_MODE_1K, m == DSL_MODE_100K};
  endfunction

  task automatic chk_code(input string what, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_flag(input string what, input logic [2:0] e, input logic [2:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // a frame executes once eighteen serial clock falls precede the host abort
  function automatic logic full_frame(input int abort_at);
    return abort_at == 0 || (abort_at + HALF) / (2 * HALF) >= EXEC_EDGE;
  endfunction

  // one frame; abort_at nonzero raises the host abort that many cycles in
  task automatic send(input dsl_mode_t m, input logic [15:0] c, input int abort_at);
    int          n;
    int          post;
    int          rec_low;
    logic        s_upd, s_abt, s_uns, e_uns, full;
    logic [15:0] e_rec;
    s_upd = 1'b0;
    s_abt = 1'b0;
    s_uns = 1'b0;
    post = 0;
    rec_low = 0;
    full = full_frame(abort_at);
    e_uns = exp_mode != DSL_MODE_NORMAL || (full && m != DSL_MODE_NORMAL);
    e_rec = (exp_mode != DSL_MODE_NORMAL && full && m == DSL_MODE_NORMAL)
            ? 16'(REC_SIM) : 16'h0000;
    for (n = 0; n < 400 && ready !== 1'b1; n++) @(posedge i_clock);
    valid <= 1'b1;
    mode <= m;
    code <= c;
    @(posedge i_clock);
    valid <= 1'b0;
    for (n = 1; n < 400 && post < 10; n++) begin
      @(posedge i_clock);
      if (n == abort_at) abort <= 1'b1;
      s_upd |= (upd === 1'b1);
      s_abt |= (abt === 1'b1);
      s_uns |= (settled === 1'b0);
      rec_low += (amp_on === 1'b1 && settled === 1'b0);
      if (post > 0 || done === 1'b1
          || (abort_at != 0 && n > abort_at && ready === 1'b1)) post++;
    end
    abort <= 1'b0;
    if (n >= 400) begin
      err_total++;
      $display("BAD frame end expected done seen timeout");
    end
    chk_code("recovery", e_rec, rec_low[15:0]);
    if (full) begin
      exp_mode = m;
      if (m == DSL_MODE_NORMAL) exp_code = c;
    end
    chk_flag("pulses", {1'b0, full, !full}, {1'b0, s_upd, s_abt});
    chk_code("code", exp_code, dev_code);
    chk_flag("mode", {1'b0, exp_mode}, {1'b0, dev_mode});
    chk_flag("outputs", exp_out(exp_mode), {amp_on, term_1k, term_100k});
    chk_flag("settle", {1'b0, e_uns, exp_mode == DSL_MODE_NORMAL}, {1'b0, s_uns, settled});
    $display("frame done mode %0d code %h abort %0d", m, c, abort_at);
  endtask

  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  initial begin
    #400000;
    err_total++;
    $display("BAD watchdog expected finish seen timeout");
    results();
  end

  initial begin
    err_total = 0;
    check_count = 0;
    rng = 32'h98be;
    i_arst_n = 1'b0;
    valid = 1'b0;
    abort = 1'b0;
    mode = DSL_MODE_NORMAL;
    code = 16'h0000;
    exp_code = CODE_RESET;
    exp_mode = MODE_RESET;
    repeat (4) @(posedge i_clock);
    chk_code("reset code", CODE_RESET, dev_code);
    chk_flag("reset outputs", exp_out(MODE_RESET), {amp_on, term_1k, term_100k});
    i_arst_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      rng = xs(rng);
      send(i < 4 ? dsl_mode_t'(i) : (i == 4 ? DSL_MODE_NORMAL : dsl_mode_t'(rng[1:0])),
           i == 0 ? 16'hffff : (i == 4 ? 16'h0000 : rng[31:16]),
           (i == 6 || i == 9) ? 40 : (i == 8 ? 149 : 0));
    end
    // mid-run reset returns code and mode to their power-up values
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk_code("rerun code", CODE_RESET, dev_code);
    chk_flag("rerun mode", {1'b0, MODE_RESET}, {1'b0, dev_mode});
    i_arst_n <= 1'b1;
    exp_code = CODE_RESET;
    exp_mode = MODE_RESET;
    send(dsl_mode_t'(rng[5:4]), rng[15:0], 0);
    results();
  end
endmodule
